/* pkg/port_io_consts.svh */
// Register offsets, field positions, reset values and bit-address layout of the port block
`ifndef PORT_IO_CONSTS_SVH
`define PORT_IO_CONSTS_SVH

// Register offsets on the special function register bus
`define ADDR_PORT_ZERO 8'h80
`define ADDR_PORT_ONE 8'h90
`define ADDR_PORT_ZERO_MASK 8'hc1
`define ADDR_PORT_ZERO_VALUE 8'hc2
`define ADDR_PORT_ONE_MASK 8'hc3
`define ADDR_PORT_ONE_VALUE 8'hc4
`define ADDR_CROSSBAR_ONE 8'he2
`define ADDR_EXT_IRQ_EN_ONE 8'he6

// Crossbar control field positions
`define XBR_PULLUP_OFF_BIT 7
`define XBR_ON_BIT 6
`define XBR_ROUTE_HI 1
`define XBR_ROUTE_LO 0
// Bit 2 is reserved and reads zero
`define XBR_WRITE_MASK 8'hfb

// Extended interrupt enable field position
`define EIE_MATCH_BIT 7

// Reset values
`define PORT_LATCH_RESET 8'hff
`define COMPARE_MASK_RESET 8'h00
`define COMPARE_VALUE_RESET 8'h00
`define XBR_RESET 8'h00
`define EIE_RESET 8'h00

// Bit address: upper five bits pick the byte, lower three the bit
`define BIT_BYTE_HI 7
`define BIT_BYTE_LO 3
`define BIT_IDX_HI 2

// Route field codes
`define ROUTE_NONE 2'h0
`define ROUTE_CH0 2'h1
`define ROUTE_CH01 2'h2
`define ROUTE_CH012 2'h3

`endif

/* pkg/port_io_pkg.sv */
// Types shared by the port block
package port_io_pkg;

    // Register selected by an address
    typedef enum logic [3:0] {
        SEL_NONE,
        SEL_PORT_ZERO,
        SEL_PORT_ONE,
        SEL_ZERO_MASK,
        SEL_ZERO_VALUE,
        SEL_ONE_MASK,
        SEL_ONE_VALUE,
        SEL_CROSSBAR,
        SEL_EXT_IRQ_EN
    } sfr_sel_t;

    // Internal oscillator state
    typedef enum logic {
        OSC_RUN,
        OSC_SUSPENDED
    } osc_state_t;

endpackage : port_io_pkg

/* rtl/crossbar_route.sv */
// Crossbar for port zero: counter channel outputs or the general-purpose latch
`timescale 1ns/1ps
`include "port_io_consts.svh"

module crossbar_route #(
    parameter int WIDTH = 8,
    parameter int CHANNELS = 3
) (
    // Configuration
    input wire logic crossbar_on,
    input wire logic [1:0] counter_array_pin_route,
    // Sources
    input wire logic [WIDTH-1:0] latch,
    input wire logic [CHANNELS-1:0] channel_out,
    // Pin drive
    output logic [WIDTH-1:0] pin_value,
    output logic [WIDTH-1:0] pin_drive
);

    logic [WIDTH-1:0] assigned;

    // Refuse sizes the route field cannot serve
    if (CHANNELS != 3 || WIDTH < CHANNELS) begin : g_size_check
        $error("crossbar_route: needs three channels and at least three pins");
    end

    always_comb begin
        assigned = '0;
        if (crossbar_on) begin
            unique case (counter_array_pin_route)
                `ROUTE_NONE: assigned = '0;
                `ROUTE_CH0: assigned[0] = 1'b1;
                `ROUTE_CH01: assigned[1:0] = 2'h3;
                `ROUTE_CH012: assigned[2:0] = 3'h7;
            endcase
        end
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        if (i < CHANNELS) begin : g_shared
            assign pin_value[i] = assigned[i] ? channel_out[i] : latch[i];
            assign pin_drive[i] = assigned[i] ? 1'b1 : ~latch[i];
        end else begin : g_plain
            assign pin_value[i] = latch[i];
            assign pin_drive[i] = ~latch[i];
        end
    end

endmodule : crossbar_route

/* rtl/match_detect.sv */
// Masked pattern mismatch detector for one port
`timescale 1ns/1ps

module match_detect #(
    parameter int WIDTH = 8
) (
    // Pin levels and compare setup
    input wire logic [WIDTH-1:0] pins,
    input wire logic [WIDTH-1:0] compare_mask,
    input wire logic [WIDTH-1:0] compare_value,
    // Result
    output logic mismatch
);

    // Refuse a width the logic cannot serve
    if (WIDTH < 1) begin : g_width_check
        $error("match_detect: WIDTH must be at least 1");
    end

    always_comb begin
        mismatch = |((pins ^ compare_value) & compare_mask);
    end

endmodule : match_detect

/* rtl/port_io_top.sv */
// Two 8-bit ports with latches, crossbar control and masked pattern match
`timescale 1ns/1ps
`include "port_io_consts.svh"

module port_io_top
    import port_io_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Byte access
    input wire logic [7:0] sfr_addr,
    input wire logic [WIDTH-1:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_rmw,
    output logic [WIDTH-1:0] sfr_rdata,
    // Bit access
    input wire logic [7:0] sfr_bit_addr,
    input wire logic sfr_bit_wdata,
    input wire logic sfr_bit_wr,
    // Port zero pins
    input wire logic [WIDTH-1:0] port_zero_in,
    input wire logic [WIDTH-1:0] port_zero_analog,
    output logic [WIDTH-1:0] port_zero_out,
    output logic [WIDTH-1:0] port_zero_oe,
    output logic [WIDTH-1:0] port_zero_pullup,
    // Port one pins
    input wire logic [WIDTH-1:0] port_one_in,
    input wire logic [WIDTH-1:0] port_one_analog,
    output logic [WIDTH-1:0] port_one_out,
    output logic [WIDTH-1:0] port_one_oe,
    output logic [WIDTH-1:0] port_one_pullup,
    // Counter array channel outputs
    input wire logic counter_channel0_out,
    input wire logic counter_channel1_out,
    input wire logic counter_channel2_out,
    // Match and oscillator
    input wire logic suspend_req,
    output logic match_event,
    output logic match_irq_request,
    output logic osc_running
);

    logic [WIDTH-1:0] port_zero;
    logic [WIDTH-1:0] port_one;
    logic [WIDTH-1:0] port_zero_compare_mask;
    logic [WIDTH-1:0] port_zero_compare_value;
    logic [WIDTH-1:0] port_one_compare_mask;
    logic [WIDTH-1:0] port_one_compare_value;
    logic [7:0] crossbar_control_one;
    logic [7:0] extended_irq_enable_one;
    logic mismatch_zero;
    logic mismatch_one;
    logic mismatch_any;
    logic [WIDTH-1:0] route_value;
    logic [WIDTH-1:0] route_drive;
    sfr_sel_t byte_sel;
    sfr_sel_t bit_sel;
    logic [2:0] bit_idx;
    osc_state_t osc_state;
    osc_state_t next_osc_state;

    // Refuse widths the byte registers cannot serve
    if (WIDTH != 8) begin : g_width_check
        $error("port_io_top: WIDTH must be 8");
    end

    // Register select from a byte address
    function automatic sfr_sel_t decode(input logic [7:0] addr);
        unique case (addr)
            `ADDR_PORT_ZERO: decode = SEL_PORT_ZERO;
            `ADDR_PORT_ONE: decode = SEL_PORT_ONE;
            `ADDR_PORT_ZERO_MASK: decode = SEL_ZERO_MASK;
            `ADDR_PORT_ZERO_VALUE: decode = SEL_ZERO_VALUE;
            `ADDR_PORT_ONE_MASK: decode = SEL_ONE_MASK;
            `ADDR_PORT_ONE_VALUE: decode = SEL_ONE_VALUE;
            `ADDR_CROSSBAR_ONE: decode = SEL_CROSSBAR;
            `ADDR_EXT_IRQ_EN_ONE: decode = SEL_EXT_IRQ_EN;
            default: decode = SEL_NONE;
        endcase
    endfunction : decode

    // Address decode for byte and bit access
    assign byte_sel = decode(sfr_addr);
    assign bit_sel = decode({sfr_bit_addr[`BIT_BYTE_HI:`BIT_BYTE_LO], 3'h0});
    assign bit_idx = sfr_bit_addr[`BIT_IDX_HI:0];

    // single-bit write touches one latch bit
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            port_zero <= `PORT_LATCH_RESET;
            port_one <= `PORT_LATCH_RESET;
        end else if (sfr_wr) begin
            if (byte_sel == SEL_PORT_ZERO) begin
                port_zero <= sfr_wdata;
            end
            if (byte_sel == SEL_PORT_ONE) begin
                port_one <= sfr_wdata;
            end
        end else if (sfr_bit_wr) begin
            if (bit_sel == SEL_PORT_ZERO) begin
                port_zero[bit_idx] <= sfr_bit_wdata;
            end
            if (bit_sel == SEL_PORT_ONE) begin
                port_one[bit_idx] <= sfr_bit_wdata;
            end
        end
    end

    // Compare setup registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            port_zero_compare_mask <= `COMPARE_MASK_RESET;
            port_zero_compare_value <= `COMPARE_VALUE_RESET;
            port_one_compare_mask <= `COMPARE_MASK_RESET;
            port_one_compare_value <= `COMPARE_VALUE_RESET;
        end else if (sfr_wr) begin
            if (byte_sel == SEL_ZERO_MASK) begin
                port_zero_compare_mask <= sfr_wdata;
            end
            if (byte_sel == SEL_ZERO_VALUE) begin
                port_zero_compare_value <= sfr_wdata;
            end
            if (byte_sel == SEL_ONE_MASK) begin
                port_one_compare_mask <= sfr_wdata;
            end
            if (byte_sel == SEL_ONE_VALUE) begin
                port_one_compare_value <= sfr_wdata;
            end
        end
    end

    // Crossbar and interrupt enable registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            crossbar_control_one <= `XBR_RESET;
            extended_irq_enable_one <= `EIE_RESET;
        end else if (sfr_wr) begin
            if (byte_sel == SEL_CROSSBAR) begin
                crossbar_control_one <= sfr_wdata & `XBR_WRITE_MASK;
            end
            if (byte_sel == SEL_EXT_IRQ_EN) begin
                extended_irq_enable_one <= sfr_wdata;
            end
        end
    end

    // Read data, one cycle after the strobe
    // plain read returns pin levels
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            unique case (byte_sel)
                SEL_PORT_ZERO: sfr_rdata <= sfr_rmw ? port_zero : port_zero_in;
                SEL_PORT_ONE: sfr_rdata <= sfr_rmw ? port_one : port_one_in;
                SEL_ZERO_MASK: sfr_rdata <= port_zero_compare_mask;
                SEL_ZERO_VALUE: sfr_rdata <= port_zero_compare_value;
                SEL_ONE_MASK: sfr_rdata <= port_one_compare_mask;
                SEL_ONE_VALUE: sfr_rdata <= port_one_compare_value;
                SEL_CROSSBAR: sfr_rdata <= crossbar_control_one;
                SEL_EXT_IRQ_EN: sfr_rdata <= extended_irq_enable_one;
                SEL_NONE: sfr_rdata <= 8'h00;
            endcase
        end
    end

    match_detect #(
        .WIDTH(WIDTH)
    ) u_match_zero (
        .pins(port_zero_in),
        .compare_mask(port_zero_compare_mask),
        .compare_value(port_zero_compare_value),
        .mismatch(mismatch_zero)
    );

    match_detect #(
        .WIDTH(WIDTH)
    ) u_match_one (
        .pins(port_one_in),
        .compare_mask(port_one_compare_mask),
        .compare_value(port_one_compare_value),
        .mismatch(mismatch_one)
    );

    assign mismatch_any = mismatch_zero | mismatch_one;

    // Counter channels share port zero low pins
    crossbar_route #(
        .WIDTH(WIDTH),
        .CHANNELS(3)
    ) u_route (
        .crossbar_on(crossbar_control_one[`XBR_ON_BIT]),
        .counter_array_pin_route(crossbar_control_one[`XBR_ROUTE_HI:`XBR_ROUTE_LO]),
        .latch(port_zero),
        .channel_out({counter_channel2_out, counter_channel1_out, counter_channel0_out}),
        .pin_value(route_value),
        .pin_drive(route_drive)
    );

    // Registered pin drive
    // crossbar result drives port zero, latch drives port one
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            port_zero_out <= `PORT_LATCH_RESET;
            port_zero_oe <= 8'h00;
            port_one_out <= `PORT_LATCH_RESET;
            port_one_oe <= 8'h00;
        end else begin
            port_zero_out <= route_value;
            port_zero_oe <= route_drive;
            port_one_out <= port_one;
            port_one_oe <= ~port_one;
        end
    end

    // pull-ups off globally or on analog pins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            port_zero_pullup <= 8'h00;
            port_one_pullup <= 8'h00;
        end else if (crossbar_control_one[`XBR_PULLUP_OFF_BIT]) begin
            port_zero_pullup <= 8'h00;
            port_one_pullup <= 8'h00;
        end else begin
            port_zero_pullup <= ~port_zero_analog;
            port_one_pullup <= ~port_one_analog;
        end
    end

    // enable bit 7 gates the request
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            match_event <= 1'b0;
            match_irq_request <= 1'b0;
        end else begin
            match_event <= mismatch_any;
            match_irq_request <= mismatch_any & extended_irq_enable_one[`EIE_MATCH_BIT];
        end
    end

    // suspend holds until a match wakes
    always_comb begin
        next_osc_state = osc_state;
        unique case (osc_state)
            OSC_RUN: begin
                if (suspend_req && !mismatch_any) begin
                    next_osc_state = OSC_SUSPENDED;
                end
            end
            OSC_SUSPENDED: begin
                if (mismatch_any) begin
                    next_osc_state = OSC_RUN;
                end
            end
        endcase
    end

    // Oscillator state and its run flag
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            osc_state <= OSC_RUN;
            osc_running <= 1'b1;
        end else begin
            osc_state <= next_osc_state;
            osc_running <= (next_osc_state == OSC_RUN);
        end
    end

    a_byte_write_latch: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (sfr_wr && byte_sel == SEL_PORT_ONE) ##2 1'b1 |->
        port_one_out == $past(sfr_wdata, 2)
    ) else $error("port one pins do not follow the written byte");

    a_pin_read_value: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (sfr_rd && !sfr_rmw && byte_sel == SEL_PORT_ZERO) |=> sfr_rdata == $past(port_zero_in)
    ) else $error("plain read did not return pin levels");

    a_rmw_read_latch: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (sfr_rd && sfr_rmw && byte_sel == SEL_PORT_ONE) |=> sfr_rdata == $past(port_one)
    ) else $error("read-modify-write read did not return the latch");

    a_bit_write_one: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (!sfr_wr && sfr_bit_wr && bit_sel == SEL_PORT_ZERO) |=>
        port_zero[$past(bit_idx)] == $past(sfr_bit_wdata) &&
        (port_zero ^ $past(port_zero)) == ((port_zero ^ $past(port_zero)) &
        (8'h01 << $past(bit_idx)))
    ) else $error("bit write changed the wrong latch bits");

    a_match_event_cause: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ##1 match_event == $past(|((port_zero_in ^ port_zero_compare_value) &
        port_zero_compare_mask) | |((port_one_in ^ port_one_compare_value) &
        port_one_compare_mask))
    ) else $error("match event does not follow the masked compare");

    a_irq_gate_enable: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        match_irq_request |-> match_event && $past(extended_irq_enable_one[7])
    ) else $error("match request raised while enable was clear");

    a_wake_on_match: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (!osc_running && mismatch_any) |=> osc_running
    ) else $error("match did not wake the oscillator");

    a_suspend_holds: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (osc_running && suspend_req && !mismatch_any) ##1 (!mismatch_any)[*2] |=> !osc_running
    ) else $error("oscillator restarted without a wake event");

    a_crossbar_off_gpio: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $past(!crossbar_control_one[6]) |-> port_zero_out == $past(port_zero)
    ) else $error("peripheral reached a pin while crossbar was off");

    a_route_channel_zero: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $past(crossbar_control_one[6] && crossbar_control_one[1:0] == 2'h1) |->
        port_zero_out[0] == $past(counter_channel0_out) && port_zero_out[1] == $past(port_zero[1])
    ) else $error("route code one did not route only channel zero");

    a_pullup_off_all: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $past(crossbar_control_one[7]) |-> port_zero_pullup == 8'h00 && port_one_pullup == 8'h00
    ) else $error("pull-ups still on after global disable");

endmodule : port_io_top

/* test/port_pins.sv */
// External circuitry on one port: outside drivers and weak pull-ups
`timescale 1ns/1ps

module port_pins (
    // Clock
    input wire logic ref_clk,
    // Device side of the pins
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    // Outside drivers
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    // Resolved pin levels
    output logic [7:0] pin_level
);
    logic float_bit = 1'b0;

    // Undriven pin without pull-up changes every cycle
    always @(posedge ref_clk) begin
        float_bit <= ~float_bit;
    end

    // Device drive first, then outside driver, then pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                pin_level[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_level[i] = ext_val[i];
            end else if (pin_pullup[i]) begin
                pin_level[i] = 1'b1;
            end else begin
                pin_level[i] = float_bit;
            end
        end
    end
endmodule : port_pins

/* test/tb_top.sv */
// Self-checking bench for the two-port block
`timescale 1ns/1ps
`include "port_io_consts.svh"

module tb_top;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic sfr_rmw = 1'b0;
    logic [7:0] sfr_rdata;
    logic [7:0] sfr_bit_addr = 8'h00;
    logic sfr_bit_wdata = 1'b0;
    logic sfr_bit_wr = 1'b0;
    logic [7:0] p0_in, p0_out, p0_oe, p0_pu, p1_in, p1_out, p1_oe, p1_pu;
    logic [7:0] p0_analog = 8'h01;
    logic [7:0] p1_analog = 8'h00;
    logic [7:0] p1_ext_en = 8'h00;
    logic [7:0] p1_ext_val = 8'h00;
    logic [2:0] chan = 3'b101;
    logic suspend_req = 1'b0;
    logic match_event, match_irq_request, osc_running;
    logic [7:0] rv;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;

    // Free-running clock
    always #5 ref_clk = ~ref_clk;

    // Block under test
    port_io_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw),
        .sfr_rdata(sfr_rdata), .sfr_bit_addr(sfr_bit_addr), .sfr_bit_wdata(sfr_bit_wdata),
        .sfr_bit_wr(sfr_bit_wr), .port_zero_in(p0_in), .port_zero_analog(p0_analog),
        .port_zero_out(p0_out), .port_zero_oe(p0_oe), .port_zero_pullup(p0_pu),
        .port_one_in(p1_in), .port_one_analog(p1_analog), .port_one_out(p1_out),
        .port_one_oe(p1_oe), .port_one_pullup(p1_pu), .counter_channel0_out(chan[0]),
        .counter_channel1_out(chan[1]), .counter_channel2_out(chan[2]),
        .suspend_req(suspend_req), .match_event(match_event),
        .match_irq_request(match_irq_request), .osc_running(osc_running));

    // Circuitry on both ports
    port_pins u_pins0 (.ref_clk(ref_clk), .pin_out(p0_out), .pin_oe(p0_oe),
        .pin_pullup(p0_pu), .ext_en(8'h00), .ext_val(8'h00), .pin_level(p0_in));
    port_pins u_pins1 (.ref_clk(ref_clk), .pin_out(p1_out), .pin_oe(p1_oe),
        .pin_pullup(p1_pu), .ext_en(p1_ext_en), .ext_val(p1_ext_val), .pin_level(p1_in));

    // Hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch = n_mismatch + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp8

    task automatic cmp1(input logic got, input logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask : cmp1

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        step(1);
        sfr_wr = 1'b0;
        step(2);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] d);
        sfr_addr = a;
        sfr_rmw = m;
        sfr_rd = 1'b1;
        step(1);
        sfr_rd = 1'b0;
        sfr_rmw = 1'b0;
        step(1);
        d = sfr_rdata;
    endtask : rd

    task automatic bwr(input logic [7:0] ba, input logic v);
        sfr_bit_addr = ba;
        sfr_bit_wdata = v;
        sfr_bit_wr = 1'b1;
        step(1);
        sfr_bit_wr = 1'b0;
        step(2);
    endtask : bwr

    // Main sequence
    initial begin
        step(10);
        sys_rst = 1'b0;
        step(2);
        // Reset values and pull-ups on all non-analog pins
        rd(`ADDR_CROSSBAR_ONE, 1'b0, rv); cmp8(rv, 8'h00);
        rd(`ADDR_EXT_IRQ_EN_ONE, 1'b0, rv); cmp8(rv, 8'h00);
        rd(`ADDR_PORT_ZERO, 1'b1, rv); cmp8(rv, 8'hff);
        cmp8(p0_pu, 8'hfe);
        cmp8(p1_pu, 8'hff);
        rd(8'h55, 1'b0, rv); cmp8(rv, 8'h00);
        // Pin read against latch read on port one
        p1_ext_en = 8'h0f;
        p1_ext_val = 8'h05;
        step(1);
        rd(`ADDR_PORT_ONE, 1'b0, rv); cmp8(rv, 8'hf5);
        rd(`ADDR_PORT_ONE, 1'b1, rv); cmp8(rv, 8'hff);
        wr(`ADDR_PORT_ONE, 8'h5a);
        cmp8(p1_out, 8'h5a);
        cmp8(p1_oe, 8'ha5);
        rd(`ADDR_PORT_ONE, 1'b0, rv); cmp8(rv, 8'h50);
        rd(`ADDR_PORT_ONE, 1'b1, rv); cmp8(rv, 8'h5a);
        // Single-bit writes on both ports
        bwr(8'h83, 1'b0);
        rd(`ADDR_PORT_ZERO, 1'b1, rv); cmp8(rv, 8'hf7);
        bwr(8'h96, 1'b1);
        rd(`ADDR_PORT_ONE, 1'b1, rv); cmp8(rv, 8'h5a);
        bwr(8'h96, 1'b0);
        rd(`ADDR_PORT_ONE, 1'b1, rv); cmp8(rv, 8'h1a);
        // Every route code with the crossbar on
        for (int r = 0; r < 4; r++) begin
            wr(`ADDR_CROSSBAR_ONE, 8'h40 | 8'(r));
            cmp8(p0_oe, 8'h08 | ((8'h01 << r) - 8'h01));
        end
        cmp8({5'h00, p0_out[2:0]}, 8'h05);
        // Routed pin still seen by the detector
        wr(`ADDR_PORT_ZERO_MASK, 8'h01);
        step(2);
        cmp1(match_event, 1'b1);
        wr(`ADDR_PORT_ZERO_MASK, 8'h00);
        wr(`ADDR_CROSSBAR_ONE, 8'h03);
        cmp8(p0_oe, 8'h08);
        wr(`ADDR_CROSSBAR_ONE, 8'hff);
        rd(`ADDR_CROSSBAR_ONE, 1'b0, rv); cmp8(rv, 8'hfb);
        cmp8(p0_pu, 8'h00);
        cmp8(p1_pu, 8'h00);
        wr(`ADDR_CROSSBAR_ONE, 8'h00);
        // Masked compare on port one, then enable gating
        wr(`ADDR_PORT_ONE_MASK, 8'h0f);
        rd(`ADDR_PORT_ONE_MASK, 1'b0, rv); cmp8(rv, 8'h0f);
        step(2);
        cmp1(match_event, 1'b0);
        p1_ext_val = 8'h02;
        step(3);
        cmp1(match_event, 1'b1);
        cmp1(match_irq_request, 1'b0);
        wr(`ADDR_EXT_IRQ_EN_ONE, 8'h80);
        step(1);
        cmp1(match_irq_request, 1'b1);
        wr(`ADDR_EXT_IRQ_EN_ONE, 8'h7f);
        step(1);
        cmp1(match_irq_request, 1'b0);
        wr(`ADDR_PORT_ONE_VALUE, 8'h02);
        step(2);
        cmp1(match_event, 1'b0);
        // Suspend, then wake on a pin change
        suspend_req = 1'b1;
        step(1);
        suspend_req = 1'b0;
        step(2);
        cmp1(osc_running, 1'b0);
        step(5);
        cmp1(osc_running, 1'b0);
        p1_ext_val = 8'h00;
        step(3);
        cmp1(osc_running, 1'b1);
        // Suspend refused while a mismatch stands
        suspend_req = 1'b1;
        step(1);
        suspend_req = 1'b0;
        step(2);
        cmp1(osc_running, 1'b1);
        // Analog pin on port one loses its pull-up
        p1_analog = 8'h10;
        step(2);
        cmp8(p1_pu, 8'hef);
        // Reset again in mid-run
        sys_rst = 1'b1;
        step(2);
        sys_rst = 1'b0;
        step(1);
        cmp8(p1_out, 8'hff);
        cmp1(osc_running, 1'b1);
        rd(`ADDR_EXT_IRQ_EN_ONE, 1'b0, rv); cmp8(rv, 8'h00);
        end_sim();
    end
endmodule : tb_top
